// file: qpipe_consts.svh
// Constants for the quad phase fetch/execute pipeline
`ifndef QPIPE_CONSTS_SVH
`define QPIPE_CONSTS_SVH
`define PHASE_COUNT 4
`define PC_WIDTH 13
`define WORD_WIDTH 14
`define DATA_WIDTH 8
`define DADDR_WIDTH 8
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define NOP_WORD 14'h0000
`endif

// file: qpipe_pkg.sv
// Types for the quad phase fetch/execute pipeline
package qpipe_pkg;
   typedef enum logic [1:0] {
      PH_ONE = 2'h0,
      PH_TWO = 2'h1,
      PH_THREE = 2'h3,
      PH_FOUR = 2'h2
   } phase_e;
   typedef struct packed {
      logic phaseOne;
      logic phaseTwo;
      logic phaseThree;
      logic phaseFour;
   } phases_s;
   typedef struct packed {
      logic valid;
      logic [13:0] word;
   } stage_s;
endpackage : qpipe_pkg

// file: phase_gen.sv
// Divide-by-four phase generator with one-hot phase outputs
`timescale 1ns/1ns
`include "qpipe_consts.svh"
module phase_gen (
   input wire logic clk,
   input wire logic arst_n,
   output qpipe_pkg::phase_e phase,
   output qpipe_pkg::phases_s phases
);
   qpipe_pkg::phase_e phase_ff;
   qpipe_pkg::phase_e nxt_phase;
   always_comb begin
      case (phase_ff)
         qpipe_pkg::PH_ONE: nxt_phase = qpipe_pkg::PH_TWO;
         qpipe_pkg::PH_TWO: nxt_phase = qpipe_pkg::PH_THREE;
         qpipe_pkg::PH_THREE: nxt_phase = qpipe_pkg::PH_FOUR;
         qpipe_pkg::PH_FOUR: nxt_phase = qpipe_pkg::PH_ONE;
         default: nxt_phase = qpipe_pkg::PH_ONE;
      endcase
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_ff <= qpipe_pkg::PH_ONE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end
   assign phase = phase_ff;
   assign phases.phaseOne = (phase_ff == qpipe_pkg::PH_ONE);
   assign phases.phaseTwo = (phase_ff == qpipe_pkg::PH_TWO);
   assign phases.phaseThree = (phase_ff == qpipe_pkg::PH_THREE);
   assign phases.phaseFour = (phase_ff == qpipe_pkg::PH_FOUR);
endmodule : phase_gen

// file: quad_phase_pipeline.sv
// Two-stage fetch/execute pipeline sequenced by four phase clocks
//
// Function
// - Clock divided by four into four non-overlapping phases forming one cycle.
// - Program counter advances once per cycle, in phase one, starting fetch.
// - Instruction word from program memory captured in phase four of fetch.
// - Fetch and execute overlap; one instruction completes per cycle.
// - Fetched word shown in instruction latch at phase one, executed phases two-four.
// - Data operand read in phase two; destination written in phase four.
// - Program counter changes take two cycles; prefetched word discarded.
// - Oscillator output pin toggles at a quarter of input rate in RC mode.
// - Master clear is active-low reset held while low.
// - Thirteen-bit counter; reset fetches address zero, interrupt address four.
`timescale 1ns/1ns
`include "qpipe_consts.svh"
module quad_phase_pipeline (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rcMode,
   input wire logic irqRequest,
   input wire logic [`WORD_WIDTH-1:0] progData,
   input wire logic execRedirect,
   input wire logic [`PC_WIDTH-1:0] execTarget,
   input wire logic execWriteEn,
   input wire logic [`DADDR_WIDTH-1:0] execDataAddr,
   input wire logic [`DATA_WIDTH-1:0] execResult,
   input wire logic [`DATA_WIDTH-1:0] dataRdData,
   output logic [`PC_WIDTH-1:0] progAddr,
   output logic [`WORD_WIDTH-1:0] instructionLatch,
   output logic execValid,
   output logic irqTaken,
   output logic dataRdEn,
   output logic dataWrEn,
   output logic [`DADDR_WIDTH-1:0] dataAddr,
   output logic [`DATA_WIDTH-1:0] dataWrData,
   output logic [`DATA_WIDTH-1:0] operand,
   output logic oscOutputPin,
   output logic phaseOne,
   output logic phaseTwo,
   output logic phaseThree,
   output logic phaseFour
);
   // master_clear_n drives arst_n; device stays reset while it is low
   qpipe_pkg::phase_e phase;
   qpipe_pkg::phases_s ph;
   qpipe_pkg::phase_e nxtPhase;

   phase_gen u_phase_gen (
      .clk(clk),
      .arst_n(arst_n),
      .phase(phase),
      .phases(ph)
   );

   function automatic qpipe_pkg::phase_e next_phase(input qpipe_pkg::phase_e p);
      case (p)
         qpipe_pkg::PH_ONE: next_phase = qpipe_pkg::PH_TWO;
         qpipe_pkg::PH_TWO: next_phase = qpipe_pkg::PH_THREE;
         qpipe_pkg::PH_THREE: next_phase = qpipe_pkg::PH_FOUR;
         default: next_phase = qpipe_pkg::PH_ONE;
      endcase
   endfunction : next_phase

   assign nxtPhase = next_phase(phase);

   logic [`PC_WIDTH-1:0] pc_ff;
   logic [`PC_WIDTH-1:0] nxt_pc;
   qpipe_pkg::stage_s exec_ff;
   qpipe_pkg::stage_s nxt_exec;
   logic irqPend_ff;
   logic nxt_irqPend;
   logic irqTaken_ff;
   logic nxt_irqTaken;
   logic rdEn_ff;
   logic nxt_rdEn;
   logic wrEn_ff;
   logic nxt_wrEn;
   logic [`DADDR_WIDTH-1:0] dAddr_ff;
   logic [`DADDR_WIDTH-1:0] nxt_dAddr;
   logic [`DATA_WIDTH-1:0] wrData_ff;
   logic [`DATA_WIDTH-1:0] nxt_wrData;
   logic [`DATA_WIDTH-1:0] operand_ff;
   logic [`DATA_WIDTH-1:0] nxt_operand;
   logic osc_ff;
   logic nxt_osc;
   qpipe_pkg::phases_s phOut_ff;
   qpipe_pkg::phases_s nxt_phOut;
   logic takeJump;
   logic takeIrq;
   logic redirect;

   // A jump outranks a pending interrupt; either one drops the word fetched meanwhile
   assign takeJump = ph.phaseFour && exec_ff.valid && execRedirect;
   assign takeIrq = ph.phaseFour && irqPend_ff && !takeJump;
   assign redirect = takeJump || takeIrq;

   // Program counter steps at the end of phase four, so it shows in phase one
   always_comb begin
      nxt_pc = pc_ff;
      if (takeJump) begin
         nxt_pc = execTarget;
      end else if (takeIrq) begin
         nxt_pc = `IRQ_VECTOR;
      end else if (ph.phaseFour) begin
         nxt_pc = pc_ff + `PC_WIDTH'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_ff <= `RESET_VECTOR;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // Word read in phase four goes straight to the instruction latch
   always_comb begin
      nxt_exec = exec_ff;
      if (ph.phaseFour) begin
         nxt_exec.word = progData;
         nxt_exec.valid = !redirect;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         exec_ff <= '0;
      end else begin
         exec_ff <= nxt_exec;
      end
   end

   always_comb begin
      nxt_irqPend = irqPend_ff | irqRequest;
      nxt_irqTaken = 1'b0;
      if (takeIrq) begin
         // A request seen in the taking cycle stays pending
         nxt_irqPend = irqRequest;
         nxt_irqTaken = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqPend_ff <= 1'b0;
         irqTaken_ff <= 1'b0;
      end else begin
         irqPend_ff <= nxt_irqPend;
         irqTaken_ff <= nxt_irqTaken;
      end
   end

   // Strobes are registered one phase ahead so they stand in their own phase
   always_comb begin
      nxt_rdEn = 1'b0;
      nxt_wrEn = 1'b0;
      nxt_dAddr = dAddr_ff;
      nxt_wrData = wrData_ff;
      nxt_operand = operand_ff;
      if (ph.phaseOne && exec_ff.valid) begin
         nxt_rdEn = 1'b1;
         nxt_dAddr = execDataAddr;
      end
      if (ph.phaseTwo && rdEn_ff) begin
         nxt_operand = dataRdData;
      end
      if (ph.phaseThree && exec_ff.valid && execWriteEn) begin
         nxt_wrEn = 1'b1;
         nxt_dAddr = execDataAddr;
         nxt_wrData = execResult;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdEn_ff <= 1'b0;
         wrEn_ff <= 1'b0;
         dAddr_ff <= '0;
         wrData_ff <= '0;
         operand_ff <= '0;
      end else begin
         rdEn_ff <= nxt_rdEn;
         wrEn_ff <= nxt_wrEn;
         dAddr_ff <= nxt_dAddr;
         wrData_ff <= nxt_wrData;
         operand_ff <= nxt_operand;
      end
   end

   // Phase flags and clock out use the coming phase so they line up with it
   always_comb begin
      nxt_phOut = '0;
      case (nxtPhase)
         qpipe_pkg::PH_ONE: nxt_phOut.phaseOne = 1'b1;
         qpipe_pkg::PH_TWO: nxt_phOut.phaseTwo = 1'b1;
         qpipe_pkg::PH_THREE: nxt_phOut.phaseThree = 1'b1;
         qpipe_pkg::PH_FOUR: nxt_phOut.phaseFour = 1'b1;
         default: nxt_phOut = '0;
      endcase
      // Clock out high for phases one and two, low for three and four
      if (rcMode) begin
         nxt_osc = (nxtPhase == qpipe_pkg::PH_ONE) || (nxtPhase == qpipe_pkg::PH_TWO);
      end else begin
         nxt_osc = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_ff <= 1'b0;
         phOut_ff <= '0;
      end else begin
         osc_ff <= nxt_osc;
         phOut_ff <= nxt_phOut;
      end
   end

   assign progAddr = pc_ff;
   assign instructionLatch = exec_ff.word;
   assign execValid = exec_ff.valid;
   assign irqTaken = irqTaken_ff;
   assign dataRdEn = rdEn_ff;
   assign dataWrEn = wrEn_ff;
   assign dataAddr = dAddr_ff;
   assign dataWrData = wrData_ff;
   assign operand = operand_ff;
   assign oscOutputPin = osc_ff;
   assign phaseOne = phOut_ff.phaseOne;
   assign phaseTwo = phOut_ff.phaseTwo;
   assign phaseThree = phOut_ff.phaseThree;
   assign phaseFour = phOut_ff.phaseFour;
endmodule : quad_phase_pipeline

// file: qpipe_memories.sv
// Program memory, data memory and decoder model facing the pipeline
`timescale 1ns/1ns
module qpipe_memories (
   input wire logic clk,
   input wire logic [12:0] progAddr,
   input wire logic [13:0] instructionLatch,
   input wire logic dataRdEn,
   input wire logic dataWrEn,
   input wire logic [7:0] dataAddr,
   input wire logic [7:0] dataWrData,
   input wire logic [7:0] operand,
   output logic [13:0] progData,
   output logic execRedirect,
   output logic [12:0] execTarget,
   output logic execWriteEn,
   output logic [7:0] execDataAddr,
   output logic [7:0] execResult,
   output logic [7:0] dataRdData
);
   logic [13:0] rom [0:31];
   logic [7:0] ram [0:255];
   assign progData = rom[progAddr[4:0]];
   assign execRedirect = instructionLatch[13];
   assign execTarget = instructionLatch[12:0];
   assign execWriteEn = !instructionLatch[13] && instructionLatch[8];
   assign execDataAddr = instructionLatch[7:0];
   assign execResult = operand + 8'h01;
   // Unselected read bus shows the inverted addressed word rather than a held value
   assign dataRdData = dataRdEn ? ram[dataAddr] : ~ram[dataAddr];
   always @(posedge clk) begin
      if (dataWrEn) begin
         ram[dataAddr] <= dataWrData;
      end
   end
endmodule : qpipe_memories

// file: qpipe_monitor.sv
// Port checker for the quad phase pipeline
`timescale 1ns/1ns
`include "qpipe_consts.svh"
module qpipe_monitor (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rcMode,
   input wire logic [13:0] progData,
   input wire logic execRedirect,
   input wire logic [12:0] execTarget,
   input wire logic execWriteEn,
   input wire logic [12:0] progAddr,
   input wire logic [13:0] instructionLatch,
   input wire logic execValid,
   input wire logic irqTaken,
   input wire logic dataRdEn,
   input wire logic dataWrEn,
   input wire logic oscOutputPin,
   input wire logic phaseOne,
   input wire logic phaseTwo,
   input wire logic phaseThree,
   input wire logic phaseFour
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_ROTATE: assert property (phaseOne |=> phaseTwo ##1 phaseThree ##1 phaseFour)
      else $error("phase order broken");
   AST_PC_STEP: assert property ($changed(progAddr) |-> phaseOne)
      else $error("pc moved outside phase one");
   AST_PC_INC: assert property (phaseFour && !(execValid && execRedirect) |=>
      irqTaken || progAddr == $past(progAddr) + 13'h1) else $error("pc not incremented");
   AST_JUMP: assert property (phaseFour && execValid && execRedirect |=>
      progAddr == $past(execTarget) && !execValid ##4 execValid) else $error("jump slot");
   AST_IRQ: assert property (irqTaken |-> phaseOne && progAddr == `IRQ_VECTOR)
      else $error("interrupt vector wrong");
   AST_LATCH: assert property (phaseFour |=> !execValid || instructionLatch == $past(progData))
      else $error("instruction word not captured");
   AST_RDEN: assert property (dataRdEn == (phaseTwo && execValid))
      else $error("operand read timing");
   AST_WREN: assert property (dataWrEn == (phaseFour && $past(execValid) && $past(execWriteEn)))
      else $error("destination write timing");
   AST_OSC: assert property (rcMode && $past(rcMode) && $rose(phaseOne) |->
      oscOutputPin ##2 !oscOutputPin) else $error("clock out pattern");
   cover property (irqTaken);
   cover property (dataWrEn);
   cover property (phaseFour && execValid && execRedirect);
endmodule : qpipe_monitor
bind quad_phase_pipeline qpipe_monitor mon (.clk, .arst_n, .rcMode, .progData, .execRedirect,
   .execTarget, .execWriteEn, .progAddr, .instructionLatch, .execValid, .irqTaken, .dataRdEn,
   .dataWrEn, .oscOutputPin, .phaseOne, .phaseTwo, .phaseThree, .phaseFour);

// file: quad_phase_fetch_execute_pipeline_bench.sv
// Self-checking bench for the quad phase pipeline
`timescale 1ns/1ns
`include "qpipe_consts.svh"
module quad_phase_fetch_execute_pipeline_bench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic rcMode = 1'b0;
   logic irqRequest = 1'b0;
   logic [13:0] progData, instructionLatch;
   logic [12:0] progAddr, execTarget;
   logic [7:0] execDataAddr, execResult, dataRdData, dataAddr, dataWrData, operand;
   logic execRedirect, execWriteEn, execValid, irqTaken, dataRdEn, dataWrEn, oscOutputPin;
   logic phaseOne, phaseTwo, phaseThree, phaseFour;
   int num_errors = 0;
   int total_checks = 0;
   always #4 clk = ~clk;
   quad_phase_pipeline dut (.clk, .arst_n, .rcMode, .irqRequest, .progData, .execRedirect,
      .execTarget, .execWriteEn, .execDataAddr, .execResult, .dataRdData, .progAddr,
      .instructionLatch, .execValid, .irqTaken, .dataRdEn, .dataWrEn, .dataAddr,
      .dataWrData, .operand, .oscOutputPin, .phaseOne, .phaseTwo, .phaseThree, .phaseFour);
   qpipe_memories mem (.clk, .progAddr, .instructionLatch, .dataRdEn, .dataWrEn, .dataAddr,
      .dataWrData, .operand, .progData, .execRedirect, .execTarget, .execWriteEn,
      .execDataAddr, .execResult, .dataRdData);
   task automatic chk_val(string what, logic [13:0] exp, logic [13:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic reset_hold();
      @(posedge clk) #1 arst_n = 1'b0;
      foreach (mem.ram[i]) begin
         mem.ram[i] = 8'(i);
      end
      repeat (3) @(posedge clk);
      #1 chk_val("pc in reset", `RESET_VECTOR, progAddr);
      chk_val("valid in reset", 14'h0, {13'h0, execValid});
      @(posedge clk) #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk_val("first slot", 14'h0, {13'h0, execValid});
   endtask : reset_hold
   task automatic run_program();
      logic [12:0] exp [6] = '{13'h0, 13'h1, 13'h2, 13'h3, 13'h8, 13'h9};
      logic [13:0] lat [6] = '{14'h0000, 14'h010A, 14'h000B, 14'h2008, 14'h0000, 14'h010D};
      logic expValid [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      int n;
      foreach (exp[i]) begin
         n = 0;
         while (progAddr !== exp[i] && n < 8) begin
            @(posedge clk) #1 n++;
         end
         chk_val("fetch address", {1'b0, exp[i]}, {1'b0, progAddr});
         if (i > 1) chk_val("cycles per fetch", 14'h4, n[13:0]);
         chk_val("exec valid", {13'h0, expValid[i]}, {13'h0, execValid});
         if (expValid[i]) chk_val("instruction latch", lat[i], instructionLatch);
      end
      repeat (5) @(posedge clk);
      #1 chk_val("written word", 14'h0B, {6'h0, mem.ram[10]});
      chk_val("flushed word", 14'h0C, {6'h0, mem.ram[12]});
      chk_val("target word", 14'h0E, {6'h0, mem.ram[13]});
      chk_val("operand", 14'h0D, {6'h0, operand});
      chk_val("write data", 14'h0E, {6'h0, dataWrData});
   endtask : run_program
   task automatic irq_entry();
      int n = 0;
      @(posedge clk) #1 irqRequest = 1'b1;
      @(posedge clk) #1 irqRequest = 1'b0;
      while (irqTaken !== 1'b1 && n < 16) begin
         @(posedge clk) #1 n++;
      end
      chk_val("interrupt taken", 14'h1, {13'h0, irqTaken});
      chk_val("interrupt fetch", {1'b0, `IRQ_VECTOR}, {1'b0, progAddr});
   endtask : irq_entry
   task automatic osc_pin();
      int n = 0;
      logic prev = 1'b0;
      @(posedge clk) #1 rcMode = 1'b1;
      // Align on a falling edge of the pin, which marks phase three
      while (!(prev === 1'b1 && oscOutputPin === 1'b0) && n < 12) begin
         prev = oscOutputPin;
         @(posedge clk) #1 n++;
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) #1 chk_val("clock out", 14'((i % 4) inside {1, 2}), {13'h0, oscOutputPin});
      end
      rcMode = 1'b0;
      repeat (4) begin
         @(posedge clk) #1 chk_val("clock out idle", 14'h0, {13'h0, oscOutputPin});
      end
   endtask : osc_pin
   initial begin
      foreach (mem.rom[i]) begin
         mem.rom[i] = `NOP_WORD;
      end
      mem.rom[0] = 14'h010A;
      mem.rom[1] = 14'h000B;
      mem.rom[2] = 14'h2008;
      mem.rom[3] = 14'h010C;
      mem.rom[8] = 14'h010D;
      reset_hold();
      run_program();
      irq_entry();
      osc_pin();
      reset_hold();
      run_program();
      test_done();
   end
   initial begin
      #20000;
      num_errors++;
      test_done();
   end
endmodule : quad_phase_fetch_execute_pipeline_bench
